// ### hw/dac_sync_fifo_datapath_cfg.sv
`timescale 1ns/1ns
`include "dac_cfg_consts.svh"
module dac_sync_fifo_datapath_cfg (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Serial port pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   // Sync engine
   input wire logic sync_lock_in,
   input wire logic phase_sample_valid,
   input wire logic [5:0] phase_sample,
   output logic [5:0] sync_phase_request,
   // FIFO pointers and hardware reset pin
   input wire logic fifo_reset_pin,
   input wire logic fifo_wr_adv,
   input wire logic fifo_rd_adv,
   // Datapath controls
   output logic premod_bypass,
   output logic inv_sinc_bypass,
   output logic skip_oscillator_mixing,
   output logic oscillator_half_scale,
   output logic phase_dc_bypass,
   // Oscillator sample path into the modulator
   input wire logic [15:0] osc_in,
   output logic [15:0] osc_out
);

   // ==========================================================
   // Pin synchronisers
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic cs_s1_q, cs_s2_q;
   logic sdi_s1_q, sdi_s2_q;
   logic frst_s1_q, frst_s2_q, frst_s3_q;
   logic sclk_rise, sclk_fall, hw_reset_rise;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         sdi_s1_q <= 1'b0;
         sdi_s2_q <= 1'b0;
         frst_s1_q <= 1'b0;
         frst_s2_q <= 1'b0;
         frst_s3_q <= 1'b0;
      end else begin
         sclk_s1_q <= spi_sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q <= spi_cs_n;
         cs_s2_q <= cs_s1_q;
         sdi_s1_q <= spi_sdi;
         sdi_s2_q <= sdi_s1_q;
         frst_s1_q <= fifo_reset_pin;
         frst_s2_q <= frst_s1_q;
         frst_s3_q <= frst_s2_q;
      end
   end

   // Serial clock must be well below a quarter of core_clk for this sampling
   assign sclk_rise = sclk_s2_q && !sclk_s3_q;
   assign sclk_fall = !sclk_s2_q && sclk_s3_q;
   assign hw_reset_rise = frst_s2_q && !frst_s3_q;

   // ==========================================================
   // Serial port engine
   dac_cfg_pkg::spi_state_e st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, wdata_q, wdata_d;
   logic [4:0] addr_q, addr_d, rd_addr;
   logic rd_q, rd_d, wr_stb_q, wr_stb_d, rd_stb_q, rd_stb_d;
   logic [7:0] rd_data;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      tx_d = tx_q;
      rd_d = rd_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_stb_d = 1'b0;
      rd_stb_d = 1'b0;
      if (cs_s2_q) begin
         st_d = dac_cfg_pkg::SPI_IDLE;
         cnt_d = '0;
      end else begin
         case (st_q)
            dac_cfg_pkg::SPI_IDLE: begin
               st_d = dac_cfg_pkg::SPI_INSTR;
               cnt_d = '0;
            end
            dac_cfg_pkg::SPI_INSTR, dac_cfg_pkg::SPI_DATA: begin
               if (sclk_rise) begin
                  sh_d = {sh_q[6:0], sdi_s2_q};
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == `SPI_LAST_BIT) begin
                     if (st_q == dac_cfg_pkg::SPI_INSTR) begin
                        rd_d = sh_d[`INSTR_READ_BIT];
                        addr_d = sh_d[4:0];
                        rd_stb_d = sh_d[`INSTR_READ_BIT];
                        tx_d = rd_data;
                        st_d = dac_cfg_pkg::SPI_DATA;
                     end else if (!rd_q) begin
                        wdata_d = sh_d;
                        wr_stb_d = 1'b1;
                     end else begin
                        tx_d = rd_data;
                        rd_stb_d = 1'b1;
                     end
                  end
               end else if (sclk_fall && st_q == dac_cfg_pkg::SPI_DATA && rd_q
                            && cnt_q != 3'h0) begin
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end
            default: begin
               st_d = dac_cfg_pkg::SPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= dac_cfg_pkg::SPI_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         tx_q <= '0;
         rd_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_stb_q <= wr_stb_d;
         rd_stb_q <= rd_stb_d;
      end
   end

   assign spi_sdo = tx_q[7];
   assign spi_sdo_oe = !cs_s2_q && (st_q == dac_cfg_pkg::SPI_DATA) && rd_q;

   // ==========================================================
   // Register state
   logic [5:0] sync_req_q, sync_req_d;
   logic [2:0] spacing_q, spacing_d;
   logic [7:0] dp_q, dp_d;
   logic locked_q, locked_d, seen_q, seen_d, lost_q, lost_d;
   logic soft_req_q, soft_req_d, soft_ack_q, soft_ack_d;
   logic hw_al_q, hw_al_d, src_soft_q, src_soft_d;
   logic soft_start, align_start, align_done, warn1, warn2;
   logic [7:0] level, avg_phase;

   assign soft_start = wr_stb_q && addr_q == `ADDR_FIFO_ALIGN_FLAGS
                       && wdata_q[`BIT_SOFT_REQ] && !soft_req_q; // R10
   assign align_start = soft_start || hw_reset_rise;

   always_comb begin
      sync_req_d = sync_req_q;
      spacing_d = spacing_q;
      dp_d = dp_q;
      soft_req_d = soft_req_q;
      // Status bits accept no host writes
      locked_d = sync_lock_in; // R4 R17
      seen_d = seen_q;
      lost_d = lost_q;
      soft_ack_d = soft_ack_q;
      hw_al_d = hw_al_q;
      src_soft_d = src_soft_q;
      if (wr_stb_q) begin
         case (addr_q)
            `ADDR_SYNC_OFFSET_TARGET: sync_req_d = wdata_q[5:0]; // R1
            `ADDR_FIFO_POINTER_SPACING: spacing_d = wdata_q[2:0];
            `ADDR_FIFO_ALIGN_FLAGS: soft_req_d = wdata_q[`BIT_SOFT_REQ];
            `ADDR_DATAPATH_STAGE_SELECT: dp_d = wdata_q & `MASK_DATAPATH; // R14 R15 R16
            default: begin
            end
         endcase
      end
      // Lost flag is cleared by reading it; a new loss in that cycle wins
      if (rd_stb_q && addr_q == `ADDR_SYNC_LOCK_FLAGS) begin
         lost_d = 1'b0;
      end
      if (sync_lock_in) begin
         seen_d = 1'b1;
      end else if (seen_q) begin
         lost_d = 1'b1; // R3
         seen_d = 1'b0;
      end
      if (align_start) begin
         src_soft_d = soft_start;
         soft_ack_d = 1'b0;
      end
      if (align_done) begin
         if (src_soft_q) begin
            soft_ack_d = 1'b1; // R11
         end else begin
            hw_al_d = 1'b1; // R12
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_req_q <= `RST_SYNC_OFFSET;
         spacing_q <= `RST_FIFO_SPACING;
         dp_q <= `RST_DATAPATH;
         soft_req_q <= 1'b0;
         locked_q <= 1'b0;
         seen_q <= 1'b0;
         lost_q <= 1'b0;
         soft_ack_q <= 1'b0;
         hw_al_q <= 1'b0;
         src_soft_q <= 1'b0;
      end else begin
         sync_req_q <= sync_req_d;
         spacing_q <= spacing_d;
         dp_q <= dp_d;
         soft_req_q <= soft_req_d;
         locked_q <= locked_d;
         seen_q <= seen_d;
         lost_q <= lost_d;
         soft_ack_q <= soft_ack_d;
         hw_al_q <= hw_al_d;
         src_soft_q <= src_soft_d;
      end
   end

   // ==========================================================
   // Read mux
   assign rd_addr = (st_q == dac_cfg_pkg::SPI_INSTR) ? {sh_q[3:0], sdi_s2_q} : addr_q;

   always_comb begin
      rd_data = 8'h00;
      case (rd_addr)
         `ADDR_SYNC_OFFSET_TARGET: rd_data = {2'b00, sync_req_q};
         `ADDR_SYNC_LOCK_FLAGS: begin
            rd_data[`BIT_SYNC_LOST] = lost_q;
            rd_data[`BIT_SYNC_LOCKED] = locked_q;
         end
         `ADDR_SYNC_MEASURED_OFFSET: rd_data = avg_phase;
         `ADDR_FIFO_POINTER_SPACING: rd_data = {5'h00, spacing_q};
         `ADDR_FIFO_ALIGN_FLAGS: begin
            rd_data[`BIT_FIFO_WARN1] = warn1;
            rd_data[`BIT_FIFO_WARN2] = warn2;
            rd_data[`BIT_SOFT_ACK] = soft_ack_q;
            rd_data[`BIT_SOFT_REQ] = soft_req_q;
            rd_data[`BIT_HW_ALIGNED] = hw_al_q;
         end
         `ADDR_FIFO_FILL_LEVEL: rd_data = level;
         `ADDR_DATAPATH_STAGE_SELECT: rd_data = dp_q;
         default: rd_data = 8'h00;
      endcase
   end

   // ==========================================================
   // Submodules
   fifo_pointer_track #(
      .PTR_W(3)
   ) u_fifo (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .align_start(align_start),
      .spacing(spacing_q),
      .wr_adv(fifo_wr_adv),
      .rd_adv(fifo_rd_adv),
      .align_done(align_done),
      .warn1(warn1),
      .warn2(warn2),
      .level(level)
   );

   sync_phase_average u_avg (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .sample_valid(phase_sample_valid),
      .sample_phase(phase_sample),
      .avg_phase(avg_phase)
   );

   // ==========================================================
   // Datapath controls and oscillator scaling
   logic [15:0] osc_q, osc_d;

   always_comb begin
      osc_d = dp_q[`BIT_OSC_HALF] ? {osc_in[15], osc_in[15:1]} : osc_in; // R15
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_q <= '0;
      end else begin
         osc_q <= osc_d;
      end
   end

   assign osc_out = osc_q;
   assign sync_phase_request = sync_req_q; // R2
   assign premod_bypass = dp_q[`BIT_BYP_PREMOD];
   assign inv_sinc_bypass = dp_q[`BIT_BYP_INV_SINC];
   assign skip_oscillator_mixing = dp_q[`BIT_BYP_OSC];
   assign oscillator_half_scale = dp_q[`BIT_OSC_HALF];
   assign phase_dc_bypass = dp_q[`BIT_BYP_PHASE_DC];

   // ==========================================================
   // Checks
   phase_request_write_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
      (wr_stb_q && addr_q == `ADDR_SYNC_OFFSET_TARGET)
      |=> sync_phase_request == $past(wdata_q[5:0]))
      else $error("phase request not taken from write");

   lost_on_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
      (seen_q && !sync_lock_in) |=> lost_q ##1 (lost_q || $past(rd_stb_q)))
      else $error("loss of lock not flagged");

   lock_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
      sync_lock_in |=> locked_q)
      else $error("lock bit does not follow lock");

   soft_ack_seq_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R11
      soft_start |=> !soft_ack_q ##1 soft_ack_q)
      else $error("soft align acknowledge missing");

   hw_align_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
      (hw_reset_rise && !soft_start) |-> ##2 hw_al_q)
      else $error("hardware align flag not set");

   bypass_write_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R14
      (wr_stb_q && addr_q == `ADDR_DATAPATH_STAGE_SELECT)
      |=> premod_bypass == $past(wdata_q[7]) && phase_dc_bypass == $past(wdata_q[2]))
      else $error("bypass controls not updated");

   half_scale_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R15
      oscillator_half_scale && $stable(oscillator_half_scale)
      |=> osc_out == {$past(osc_in[15]), $past(osc_in[15:1])})
      else $error("oscillator input not halved");

   status_write_ignored_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R17
      (wr_stb_q && addr_q == `ADDR_SYNC_LOCK_FLAGS && !sync_lock_in && !seen_q)
      |=> lost_q == $past(lost_q) && !locked_q)
      else $error("status bits changed by a write");

endmodule // dac_sync_fifo_datapath_cfg

// ### hw/dac_cfg_consts.svh
// Function
// (R1) Hold six-bit requested sync phase offset, zero to sixty-three sample cycles.
// (R2) Drive the requested offset to the sync engine to skew the output.
// (R3) Set loss-of-lock bit 7 of register 0x12 when lock is lost after being achieved.
// (R4) Set lock bit 6 of the sync status register once lock is attained.
// (R5) Report averaged measured sync phase as unsigned 6.2 value, quarter-cycle steps.
// (R6) Host treats a readback differing from the request as sync timing errors.
// (R7) On each FIFO reset, write pointer leads read pointer by spacing, reset 4.
// (R8) Warning flag bit 7 while pointers are within one position.
// (R9) Warning flag bit 6 while pointers are within two positions.
// (R10) Writing one to bit 1 of FIFO status requests pointer realignment.
// (R11) Soft-align acknowledge bit 2 sets after a port-started realignment.
// (R12) Bit 0 sets when pointers are aligned after a hardware reset.
// (R13) Present FIFO fill level as eight-bit thermometer code.
// (R14) Bypass bits 7, 6, 5 skip premodulator, inverse sinc, oscillator; reset one.
// (R15) Bit 3 scales oscillator input to the modulator by one half.
// (R16) Bit 2 bypasses phase and dc compensation; resets to one.
// (R17) Host writes to status-only bits are ignored.
// (R18) Warnings and level follow the live pointer difference, unlatched.
`ifndef DAC_CFG_CONSTS_SVH
`define DAC_CFG_CONSTS_SVH

// =====================================
// Register offsets
`define ADDR_SYNC_OFFSET_TARGET 5'h11
`define ADDR_SYNC_LOCK_FLAGS 5'h12
`define ADDR_SYNC_MEASURED_OFFSET 5'h13
`define ADDR_FIFO_POINTER_SPACING 5'h17
`define ADDR_FIFO_ALIGN_FLAGS 5'h18
`define ADDR_FIFO_FILL_LEVEL 5'h19
`define ADDR_DATAPATH_STAGE_SELECT 5'h1b

// =====================================
// Field positions
`define BIT_SYNC_LOST 7
`define BIT_SYNC_LOCKED 6
`define BIT_FIFO_WARN1 7
`define BIT_FIFO_WARN2 6
`define BIT_SOFT_ACK 2
`define BIT_SOFT_REQ 1
`define BIT_HW_ALIGNED 0
`define BIT_BYP_PREMOD 7
`define BIT_BYP_INV_SINC 6
`define BIT_BYP_OSC 5
`define BIT_OSC_HALF 3
`define BIT_BYP_PHASE_DC 2
`define INSTR_READ_BIT 7

// =====================================
// Reset values and masks
`define RST_SYNC_OFFSET 6'h00
`define RST_FIFO_SPACING 3'h4
`define RST_DATAPATH 8'he4
`define MASK_DATAPATH 8'hec
`define SPI_LAST_BIT 3'h7
`define AVG_SAMPLES 3'h4

`endif

// ### hw/dac_cfg_pkg.sv
package dac_cfg_pkg;

   typedef enum logic [1:0] {
      SPI_IDLE,
      SPI_INSTR,
      SPI_DATA
   } spi_state_e;

endpackage

// ### hw/fifo_pointer_track.sv
`timescale 1ns/1ns
`include "dac_cfg_consts.svh"
module fifo_pointer_track #(
   parameter int PTR_W = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Control
   input wire logic align_start,
   input wire logic [PTR_W-1:0] spacing,
   input wire logic wr_adv,
   input wire logic rd_adv,
   // Status
   output logic align_done,
   output logic warn1,
   output logic warn2,
   output logic [(1<<PTR_W)-1:0] level
);
   logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d, diff;
   logic done_q, done_d;

   function automatic logic [(1<<PTR_W)-1:0] thermo(input logic [PTR_W-1:0] n);
      logic [(1<<PTR_W)-1:0] t;
      t = '0;
      for (int i = 0; i < (1<<PTR_W); i++) begin
         t[i] = (PTR_W'(i) < n);
      end
      return t;
   endfunction

   always_comb begin
      wr_d = wr_adv ? wr_q + 1'b1 : wr_q;
      rd_d = rd_adv ? rd_q + 1'b1 : rd_q;
      done_d = align_start;
      if (align_start) begin
         wr_d = rd_q + spacing; // R7
         rd_d = rd_q;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         done_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         done_q <= done_d;
      end
   end

   // Live difference, no latching of the flags
   assign diff = wr_q - rd_q; // R18
   assign warn1 = (diff <= PTR_W'(1)) || (diff >= PTR_W'((1<<PTR_W)-1)); // R8
   assign warn2 = (diff <= PTR_W'(2)) || (diff >= PTR_W'((1<<PTR_W)-2)); // R9
   assign level = thermo(diff); // R13
   assign align_done = done_q;

   spacing_after_align_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
      align_start |=> diff == $past(spacing))
      else $error("pointer spacing wrong after realign");

   warn_nesting_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
      warn1 |-> warn2)
      else $error("near warning without far warning");

endmodule // fifo_pointer_track

// ### hw/sync_phase_average.sv
`timescale 1ns/1ns
`include "dac_cfg_consts.svh"
module sync_phase_average (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Measured phase in whole sample cycles
   input wire logic sample_valid,
   input wire logic [5:0] sample_phase,
   // Averaged phase, 6.2 format
   output logic [7:0] avg_phase
);
   logic [7:0] acc_q, acc_d, avg_q, avg_d;
   logic [2:0] cnt_q, cnt_d;

   // Four samples summed is the mean with two fraction bits, no divider needed
   always_comb begin
      acc_d = acc_q;
      cnt_d = cnt_q;
      avg_d = avg_q;
      if (sample_valid) begin
         if (cnt_q == `AVG_SAMPLES - 3'h1) begin
            avg_d = acc_q + {2'b00, sample_phase}; // R5
            acc_d = '0;
            cnt_d = '0;
         end else begin
            acc_d = acc_q + {2'b00, sample_phase};
            cnt_d = cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_q <= '0;
         cnt_q <= '0;
         avg_q <= '0;
      end else begin
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         avg_q <= avg_d;
      end
   end

   assign avg_phase = avg_q;

   avg_update_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
      (sample_valid && cnt_q == 3'h3) |=> avg_phase == $past(acc_q) + {2'b00, $past(sample_phase)})
      else $error("averaged phase not the four-sample sum");

endmodule // sync_phase_average

// ### tb/dac_sync_fifo_datapath_cfg_tb.sv
`timescale 1ns/1ns
`include "dac_cfg_consts.svh"
`define CMP(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED %s expected %h seen %h", what, (exp), (got)); end end
module dac_sync_fifo_datapath_cfg_tb;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic spi_sclk = 1'b0, spi_cs_n = 1'b1, spi_sdi = 1'b0;
   logic spi_sdo, spi_sdo_oe;
   logic sync_lock_in = 1'b0, phase_sample_valid = 1'b0;
   logic [5:0] phase_sample = 6'h00;
   logic [5:0] sync_phase_request;
   logic fifo_reset_pin = 1'b0, fifo_wr_adv = 1'b0, fifo_rd_adv = 1'b0;
   logic premod_bypass, inv_sinc_bypass, skip_oscillator_mixing, oscillator_half_scale;
   logic phase_dc_bypass;
   logic [4:0] dp_out_bus;
   logic [15:0] osc_in = 16'h0000;
   logic [15:0] osc_out;
   logic [31:0] seed = 32'h2d7c;
   int miscompares = 0;
   int n_checks = 0;
   // Bench model of pointer spacing and alignment status
   int diff = 0;
   logic soft_ack = 1'b0, soft_req = 1'b0, hw_al = 1'b0;

   dac_sync_fifo_datapath_cfg dut (
      .core_clk(core_clk), .arst_n(arst_n),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .sync_lock_in(sync_lock_in), .phase_sample_valid(phase_sample_valid),
      .phase_sample(phase_sample), .sync_phase_request(sync_phase_request),
      .fifo_reset_pin(fifo_reset_pin), .fifo_wr_adv(fifo_wr_adv), .fifo_rd_adv(fifo_rd_adv),
      .premod_bypass(premod_bypass), .inv_sinc_bypass(inv_sinc_bypass),
      .skip_oscillator_mixing(skip_oscillator_mixing),
      .oscillator_half_scale(oscillator_half_scale), .phase_dc_bypass(phase_dc_bypass),
      .osc_in(osc_in), .osc_out(osc_out)
   );

   always #10 core_clk = ~core_clk;

   assign dp_out_bus = {premod_bypass, inv_sinc_bypass, skip_oscillator_mixing,
      oscillator_half_scale, phase_dc_bypass};

   // =====================================
   // Helpers
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] fifo_flags();
      return {(diff <= 1 || diff == 7), (diff <= 2 || diff >= 6), 3'b000, soft_ack, soft_req,
         hw_al};
   endfunction

   function automatic logic [7:0] thermo();
      return 8'((9'h001 << diff) - 9'h001);
   endfunction

   // Half periods of five core cycles keep sclk well under core_clk/4
   task automatic spi_frame(input logic rd, input logic [4:0] a, input logic [7:0] wd,
      output logic [7:0] rdat);
      logic [15:0] sh;
      sh = {rd, 2'b00, a, wd};
      rdat = 8'h00;
      @(negedge core_clk);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = sh[i];
         repeat (5) @(negedge core_clk);
         if (i < 8) rdat = {rdat[6:0], spi_sdo};
         if (i == 0) `CMP("sdo_oe", rd, spi_sdo_oe)
         spi_sclk = 1'b1;
         repeat (5) @(negedge core_clk);
         spi_sclk = 1'b0;
      end
      repeat (5) @(negedge core_clk);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      repeat (5) @(negedge core_clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] x;
      spi_frame(1'b0, a, d, x);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string nm);
      logic [7:0] x;
      spi_frame(1'b1, a, 8'h00, x);
      `CMP(nm, e, x)
   endtask

   task automatic osc_run(input logic half);
      logic [15:0] prev;
      prev = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         @(negedge core_clk);
         if (i > 0) `CMP("osc_out", (half ? {prev[15], prev[15:1]} : prev), osc_out)
         seed = lfsr_step(seed);
         prev = seed[15:0];
         osc_in = prev;
      end
   endtask

   // Random pointer traffic, both directions, so the spacing drifts
   task automatic ptr_traffic();
      for (int i = 0; i < 12; i++) begin
         @(negedge core_clk);
         seed = lfsr_step(seed);
         fifo_wr_adv = seed[0];
         fifo_rd_adv = seed[1];
         diff = (diff + int'(seed[0]) - int'(seed[1]) + 8) % 8;
      end
      @(negedge core_clk);
      fifo_wr_adv = 1'b0;
      fifo_rd_adv = 1'b0;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // =====================================
   // Watchdog
   initial begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      close_out();
   end

   // =====================================
   // Main sequence
   initial begin
      logic [7:0] v;
      logic [7:0] sum;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      `CMP("dp_out", 5'b11101, dp_out_bus)
      `CMP("phase_req", 6'h00, sync_phase_request)
      rd_chk(`ADDR_SYNC_OFFSET_TARGET, 8'h00, "reg11");
      rd_chk(`ADDR_SYNC_LOCK_FLAGS, 8'h00, "reg12");
      rd_chk(`ADDR_SYNC_MEASURED_OFFSET, 8'h00, "reg13");
      rd_chk(`ADDR_FIFO_POINTER_SPACING, 8'h04, "reg17");
      rd_chk(`ADDR_FIFO_ALIGN_FLAGS, 8'hc0, "reg18");
      rd_chk(`ADDR_FIFO_FILL_LEVEL, 8'h00, "reg19");
      rd_chk(`ADDR_DATAPATH_STAGE_SELECT, 8'he4, "reg1b");
      wr(5'h05, 8'hff);
      rd_chk(5'h05, 8'h00, "unmapped");
      // Status-only registers must shrug off writes
      wr(`ADDR_SYNC_LOCK_FLAGS, 8'hff);
      wr(`ADDR_SYNC_MEASURED_OFFSET, 8'hff);
      wr(`ADDR_FIFO_FILL_LEVEL, 8'hff);
      rd_chk(`ADDR_SYNC_LOCK_FLAGS, 8'h00, "ro12");
      rd_chk(`ADDR_SYNC_MEASURED_OFFSET, 8'h00, "ro13");
      rd_chk(`ADDR_FIFO_FILL_LEVEL, 8'h00, "ro19");
      for (int i = 0; i < 3; i++) begin
         seed = lfsr_step(seed);
         v = (i == 0) ? 8'hff : seed[7:0];
         wr(`ADDR_SYNC_OFFSET_TARGET, v);
         rd_chk(`ADDR_SYNC_OFFSET_TARGET, v & 8'h3f, "reg11");
         `CMP("phase_req", v[5:0], sync_phase_request)
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr_step(seed);
         v = seed[7:0];
         v[3] = i[0];
         if (i == 2) v = 8'hff;
         if (i == 3) v = 8'h00;
         wr(`ADDR_DATAPATH_STAGE_SELECT, v);
         rd_chk(`ADDR_DATAPATH_STAGE_SELECT, v & `MASK_DATAPATH, "reg1b");
         `CMP("dp_out", ({v[7], v[6], v[5], v[3], v[2]}), dp_out_bus)
         osc_run(v[3]);
      end
      // Phase averaging: first group at the requested top code, second random
      wr(`ADDR_SYNC_OFFSET_TARGET, 8'h3f);
      for (int g = 0; g < 2; g++) begin
         sum = 8'h00;
         for (int k = 0; k < 4; k++) begin
            @(negedge core_clk);
            seed = lfsr_step(seed);
            phase_sample = (g == 0) ? 6'h3f : seed[5:0];
            phase_sample_valid = 1'b1;
            sum = sum + {2'b00, phase_sample};
            @(negedge core_clk);
            phase_sample_valid = 1'b0;
         end
         repeat (3) @(negedge core_clk);
         rd_chk(`ADDR_SYNC_MEASURED_OFFSET, sum, "reg13");
         // Host view: a readback off the request means sync timing trouble
         if (g == 0) rd_chk(`ADDR_SYNC_MEASURED_OFFSET, {6'h3f, 2'b00}, "phase_vs_req");
      end
      sync_lock_in = 1'b1;
      repeat (3) @(negedge core_clk);
      rd_chk(`ADDR_SYNC_LOCK_FLAGS, 8'h40, "lock");
      sync_lock_in = 1'b0;
      repeat (3) @(negedge core_clk);
      rd_chk(`ADDR_SYNC_LOCK_FLAGS, 8'h80, "lost");
      rd_chk(`ADDR_SYNC_LOCK_FLAGS, 8'h00, "lost_clr");
      // Soft realignment from the serial port, status bits written as ones
      ptr_traffic();
      rd_chk(`ADDR_FIFO_FILL_LEVEL, thermo(), "level");
      wr(`ADDR_FIFO_ALIGN_FLAGS, 8'hff);
      diff = 4;
      soft_req = 1'b1;
      soft_ack = 1'b1;
      rd_chk(`ADDR_FIFO_ALIGN_FLAGS, fifo_flags(), "soft");
      wr(`ADDR_FIFO_ALIGN_FLAGS, 8'h00);
      soft_req = 1'b0;
      rd_chk(`ADDR_FIFO_ALIGN_FLAGS, fifo_flags(), "soft_hold");
      // Hardware realignment over every spacing value
      for (int s = 0; s < 8; s++) begin
         seed = lfsr_step(seed);
         wr(`ADDR_FIFO_POINTER_SPACING, {seed[7:3], 3'(s)});
         rd_chk(`ADDR_FIFO_POINTER_SPACING, {5'b00000, 3'(s)}, "reg17");
         @(negedge core_clk);
         fifo_reset_pin = 1'b1;
         repeat (4) @(negedge core_clk);
         fifo_reset_pin = 1'b0;
         repeat (10) @(negedge core_clk);
         diff = s;
         hw_al = 1'b1;
         soft_ack = 1'b0;
         rd_chk(`ADDR_FIFO_FILL_LEVEL, thermo(), "level");
         rd_chk(`ADDR_FIFO_ALIGN_FLAGS, fifo_flags(), "hw");
         ptr_traffic();
         rd_chk(`ADDR_FIFO_FILL_LEVEL, thermo(), "level");
         rd_chk(`ADDR_FIFO_ALIGN_FLAGS, fifo_flags(), "warn");
      end
      close_out();
   end
endmodule // dac_sync_fifo_datapath_cfg_tb
